// File: src/ocb_pkg.sv
// ****************************************************************
// Control and bulk list pointer constants
// ****************************************************************
package ocb_pkg;

    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned PTR_LSB = 4;
    localparam int unsigned PTR_W   = DATA_W - PTR_LSB;

    // Register offsets from the base address register
    localparam logic [ADDR_W-1:0] CTRL_CUR_OFFSET   = 8'h24;
    localparam logic [ADDR_W-1:0] BULK_FIRST_OFFSET = 8'h28;
    localparam logic [ADDR_W-1:0] BULK_CUR_OFFSET   = 8'h2c;

    // Reset values, reserved low bits and unmapped read value
    localparam logic [PTR_W-1:0]  PTR_RESET      = 28'h000_0000;
    localparam logic [PTR_LSB-1:0] RSVD_VALUE    = 4'h0;
    localparam logic [DATA_W-1:0] RDATA_RESET    = 32'h0000_0000;
    localparam logic [DATA_W-1:0] UNMAPPED_VALUE = 32'h0000_0000;

    // Bit positions in the command status and control registers
    localparam int unsigned CTRL_LIST_FILLED_BIT = 1;
    localparam int unsigned BULK_LIST_FILLED_BIT = 2;
    localparam int unsigned CTRL_LIST_EN_BIT     = 4;
    localparam int unsigned BULK_LIST_EN_BIT     = 5;

endpackage

// File: src/ocb_list_ptr.sv
`timescale 1ns/100ps

// ****************************************************************
// One list walking pointer: advance, wrap to head, software load
// ****************************************************************
module ocb_list_ptr
    import ocb_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              sw_wr_in,
    input  wire logic [PTR_W-1:0]  sw_data_in,
    input  wire logic              served_in,
    input  wire logic [PTR_W-1:0]  next_in,
    input  wire logic              list_end_in,
    input  wire logic              filled_in,
    input  wire logic [PTR_W-1:0]  head_in,
    output logic      [PTR_W-1:0]  ptr_out,
    output logic                   clear_filled_out,
    output logic                   at_end_out
);

    logic [PTR_W-1:0] ptr;
    logic [PTR_W-1:0] next_ptr;
    logic             wrap;

    // Wrap only when the list end is reached and the filled flag is set
    assign wrap = list_end_in && filled_in && !served_in;

    always_comb begin
        next_ptr = ptr;
        if (sw_wr_in) begin
            next_ptr = sw_data_in;
        end else if (served_in) begin
            // Follow the descriptor's own link, keeping insertion order
            next_ptr = next_in;
        end else if (wrap) begin
            next_ptr = head_in;
        end
    end

    // Pointer is never cleared at a frame boundary, so work resumes
    // where the previous frame stopped
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ptr <= PTR_RESET;
        end else begin
            ptr <= next_ptr;
        end
    end

    assign ptr_out          = ptr;
    assign clear_filled_out = wrap && !sw_wr_in;
    // Zero marks the end of the list
    assign at_end_out       = (ptr == PTR_RESET);

endmodule

// File: src/ocb_list_pointers.sv
`timescale 1ns/100ps

module ocb_list_pointers
    import ocb_pkg::*;
(
    input  wire logic                       CORE_CLK_IN,
    input  wire logic                       RESETN_IN,
    input  wire logic [ocb_pkg::ADDR_W-1:0] REG_ADDR_IN,
    input  wire logic                       REG_WR_IN,
    input  wire logic                       REG_RD_IN,
    input  wire logic [ocb_pkg::DATA_W-1:0] REG_WDATA_IN,
    output logic      [ocb_pkg::DATA_W-1:0] REG_RDATA_OUT,
    output logic                            REG_RDATA_VALID_OUT,
    input  wire logic [ocb_pkg::DATA_W-1:0] CTRL_REG_IN,
    input  wire logic [ocb_pkg::DATA_W-1:0] CMD_STATUS_IN,
    output logic      [ocb_pkg::DATA_W-1:0] CMD_STATUS_CLR_OUT,
    input  wire logic                       INIT_LOAD_IN,
    input  wire logic [ocb_pkg::DATA_W-1:0] HOST_COMM_AREA_BULK_FIRST_IN,
    input  wire logic [ocb_pkg::DATA_W-1:0] CTRL_FIRST_PTR_IN,
    input  wire logic                       CTRL_ED_SERVED_IN,
    input  wire logic [ocb_pkg::DATA_W-1:0] CTRL_NEXT_ED_IN,
    input  wire logic                       CTRL_LIST_END_IN,
    input  wire logic                       BULK_ED_SERVED_IN,
    input  wire logic [ocb_pkg::DATA_W-1:0] BULK_NEXT_ED_IN,
    input  wire logic                       BULK_LIST_END_IN,
    output logic      [ocb_pkg::DATA_W-1:0] CTRL_CUR_PTR_OUT,
    output logic      [ocb_pkg::DATA_W-1:0] BULK_FIRST_PTR_OUT,
    output logic      [ocb_pkg::DATA_W-1:0] BULK_CUR_PTR_OUT,
    output logic                            CTRL_AT_END_OUT,
    output logic                            BULK_AT_END_OUT
);

    // ****************************************************************
    // Address decode and write gating
    // ****************************************************************
    logic             sel_ctrl_cur;
    logic             sel_bulk_first;
    logic             sel_bulk_cur;
    logic             ctrl_list_en;
    logic             bulk_list_en;
    logic             ctrl_list_filled;
    logic             bulk_list_filled;
    logic             bulk_cur_wr;
    logic             bulk_first_wr;
    logic [PTR_W-1:0] ctrl_cur_ptr;
    logic [PTR_W-1:0] bulk_cur_ptr;
    logic [PTR_W-1:0] bulk_first_ptr;
    logic             ctrl_clr;
    logic             bulk_clr;

    always_comb begin
        sel_ctrl_cur   = 1'b0;
        sel_bulk_first = 1'b0;
        sel_bulk_cur   = 1'b0;
        if (REG_ADDR_IN == CTRL_CUR_OFFSET) begin
            sel_ctrl_cur = 1'b1;
        end else if (REG_ADDR_IN == BULK_FIRST_OFFSET) begin
            sel_bulk_first = 1'b1;
        end else if (REG_ADDR_IN == BULK_CUR_OFFSET) begin
            sel_bulk_cur = 1'b1;
        end
    end

    assign ctrl_list_en     = CTRL_REG_IN[CTRL_LIST_EN_BIT];
    assign bulk_list_en     = CTRL_REG_IN[BULK_LIST_EN_BIT];
    assign ctrl_list_filled = CMD_STATUS_IN[CTRL_LIST_FILLED_BIT];
    assign bulk_list_filled = CMD_STATUS_IN[BULK_LIST_FILLED_BIT];

    // Bulk current writes while the bulk list is enabled would race the walker; drop them
    assign bulk_cur_wr   = REG_WR_IN && sel_bulk_cur && !bulk_list_en;
    assign bulk_first_wr = REG_WR_IN && sel_bulk_first;

    // ****************************************************************
    // Control list walker
    // ****************************************************************
    // Software write port tied off: the control current pointer is read-only
    ocb_list_ptr u_ctrl_walk (
        .clk_in           (CORE_CLK_IN),
        .rst_n_in         (RESETN_IN),
        .sw_wr_in         (1'b0),
        .sw_data_in       (PTR_RESET),
        .served_in        (CTRL_ED_SERVED_IN),
        .next_in          (CTRL_NEXT_ED_IN[DATA_W-1:PTR_LSB]),
        .list_end_in      (CTRL_LIST_END_IN),
        .filled_in        (ctrl_list_filled),
        .head_in          (CTRL_FIRST_PTR_IN[DATA_W-1:PTR_LSB]),
        .ptr_out          (ctrl_cur_ptr),
        .clear_filled_out (ctrl_clr),
        .at_end_out       (CTRL_AT_END_OUT)
    );

    // ****************************************************************
    // Bulk head pointer
    // ****************************************************************
    // Init load wins over a software write in the same cycle
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RESETN_IN) begin
            bulk_first_ptr <= PTR_RESET;
        end else if (INIT_LOAD_IN) begin
            bulk_first_ptr <= HOST_COMM_AREA_BULK_FIRST_IN[DATA_W-1:PTR_LSB];
        end else if (bulk_first_wr) begin
            bulk_first_ptr <= REG_WDATA_IN[DATA_W-1:PTR_LSB];
        end
    end

    // ****************************************************************
    // Bulk list walker
    // ****************************************************************
    ocb_list_ptr u_bulk_walk (
        .clk_in           (CORE_CLK_IN),
        .rst_n_in         (RESETN_IN),
        .sw_wr_in         (bulk_cur_wr),
        .sw_data_in       (REG_WDATA_IN[DATA_W-1:PTR_LSB]),
        .served_in        (BULK_ED_SERVED_IN),
        .next_in          (BULK_NEXT_ED_IN[DATA_W-1:PTR_LSB]),
        .list_end_in      (BULK_LIST_END_IN),
        .filled_in        (bulk_list_filled),
        .head_in          (bulk_first_ptr),
        .ptr_out          (bulk_cur_ptr),
        .clear_filled_out (bulk_clr),
        .at_end_out       (BULK_AT_END_OUT)
    );

    // ****************************************************************
    // Flag clears and pointer outputs
    // ****************************************************************
    always_comb begin
        CMD_STATUS_CLR_OUT                       = '0;
        CMD_STATUS_CLR_OUT[CTRL_LIST_FILLED_BIT] = ctrl_clr;
        CMD_STATUS_CLR_OUT[BULK_LIST_FILLED_BIT] = bulk_clr;
    end

    assign CTRL_CUR_PTR_OUT   = {ctrl_cur_ptr, RSVD_VALUE};
    assign BULK_FIRST_PTR_OUT = {bulk_first_ptr, RSVD_VALUE};
    assign BULK_CUR_PTR_OUT   = {bulk_cur_ptr, RSVD_VALUE};

    // ****************************************************************
    // Register read
    // ****************************************************************
    logic [DATA_W-1:0] next_rdata;

    always_comb begin
        next_rdata = UNMAPPED_VALUE;
        if (sel_ctrl_cur) begin
            next_rdata = {ctrl_cur_ptr, RSVD_VALUE};
        end else if (sel_bulk_first) begin
            next_rdata = {bulk_first_ptr, RSVD_VALUE};
        end else if (sel_bulk_cur) begin
            next_rdata = {bulk_cur_ptr, RSVD_VALUE};
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RESETN_IN) begin
            REG_RDATA_OUT <= RDATA_RESET;
        end else if (REG_RD_IN) begin
            REG_RDATA_OUT <= next_rdata;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RESETN_IN) begin
            REG_RDATA_VALID_OUT <= 1'b0;
        end else begin
            REG_RDATA_VALID_OUT <= REG_RD_IN;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    // Idle and wrap steps shared by the walker properties
    sequence ctrl_quiet_s;
        !CTRL_ED_SERVED_IN && !CTRL_LIST_END_IN;
    endsequence

    sequence bulk_quiet_s;
        !BULK_ED_SERVED_IN && !BULK_LIST_END_IN && !bulk_cur_wr;
    endsequence

    sequence ctrl_wrap_s;
        CTRL_LIST_END_IN && ctrl_list_filled && !CTRL_ED_SERVED_IN;
    endsequence

    sequence bulk_wrap_s;
        BULK_LIST_END_IN && bulk_list_filled && !BULK_ED_SERVED_IN && !bulk_cur_wr;
    endsequence

    ctrl_advance_a: assert property (
        CTRL_ED_SERVED_IN |=> CTRL_CUR_PTR_OUT ==
            {$past(CTRL_NEXT_ED_IN[DATA_W-1:PTR_LSB]), RSVD_VALUE})
        else $error("control pointer did not advance");

    ctrl_resume_a: assert property (
        ctrl_quiet_s [*3] |=> $stable(CTRL_CUR_PTR_OUT))
        else $error("control pointer moved while idle");

    ctrl_wrap_a: assert property (
        ctrl_wrap_s |-> CMD_STATUS_CLR_OUT[CTRL_LIST_FILLED_BIT]
            ##1 CTRL_CUR_PTR_OUT ==
            {$past(CTRL_FIRST_PTR_IN[DATA_W-1:PTR_LSB]), RSVD_VALUE})
        else $error("control list wrap wrong");

    ctrl_nowrap_a: assert property (
        CTRL_LIST_END_IN && !ctrl_list_filled && !CTRL_ED_SERVED_IN
            |-> !CMD_STATUS_CLR_OUT[CTRL_LIST_FILLED_BIT]
            ##1 $stable(CTRL_CUR_PTR_OUT))
        else $error("control pointer changed with flag clear");

    ctrl_readonly_a: assert property (
        (REG_WR_IN && sel_ctrl_cur) and ctrl_quiet_s |=> $stable(CTRL_CUR_PTR_OUT))
        else $error("control pointer took a software write");

    reset_zero_a: assert property (
        $rose(RESETN_IN) |-> CTRL_CUR_PTR_OUT == '0 && BULK_CUR_PTR_OUT == '0
            && BULK_FIRST_PTR_OUT == '0 && CTRL_AT_END_OUT)
        else $error("pointers not zero after reset");

    bulk_first_a: assert property (
        bulk_first_wr && !INIT_LOAD_IN |=> BULK_FIRST_PTR_OUT ==
            {$past(REG_WDATA_IN[DATA_W-1:PTR_LSB]), RSVD_VALUE})
        else $error("bulk head write lost");

    bulk_init_a: assert property (
        INIT_LOAD_IN |=> BULK_FIRST_PTR_OUT ==
            {$past(HOST_COMM_AREA_BULK_FIRST_IN[DATA_W-1:PTR_LSB]), RSVD_VALUE})
        else $error("bulk head not loaded at init");

    bulk_wrap_a: assert property (
        bulk_wrap_s
            |=> BULK_CUR_PTR_OUT == $past(BULK_FIRST_PTR_OUT))
        else $error("bulk traversal not restarted at head");

    bulk_advance_a: assert property (
        BULK_ED_SERVED_IN && !bulk_cur_wr |=> BULK_CUR_PTR_OUT ==
            {$past(BULK_NEXT_ED_IN[DATA_W-1:PTR_LSB]), RSVD_VALUE})
        else $error("bulk pointer did not advance");

    bulk_hold_a: assert property (
        bulk_quiet_s |=> $stable(BULK_CUR_PTR_OUT))
        else $error("bulk pointer moved while idle");

    bulk_gate_a: assert property (
        REG_WR_IN && sel_bulk_cur && bulk_list_en
            && !BULK_ED_SERVED_IN && !BULK_LIST_END_IN
            |=> $stable(BULK_CUR_PTR_OUT))
        else $error("bulk pointer written while list enabled");

    read_low_a: assert property (
        REG_RD_IN |=> REG_RDATA_VALID_OUT && REG_RDATA_OUT[PTR_LSB-1:0] == '0)
        else $error("read answer late or low bits set");

    bulk_sw_write_a: assert property (
        bulk_cur_wr |=> BULK_CUR_PTR_OUT ==
            {$past(REG_WDATA_IN[DATA_W-1:PTR_LSB]), RSVD_VALUE})
        else $error("bulk pointer write lost");

    bulk_clr_a: assert property (
        bulk_wrap_s |-> CMD_STATUS_CLR_OUT[BULK_LIST_FILLED_BIT])
        else $error("bulk filled flag not cleared on wrap");

    bulk_nowrap_a: assert property (
        BULK_LIST_END_IN && !bulk_list_filled && !BULK_ED_SERVED_IN && !bulk_cur_wr
            |-> !CMD_STATUS_CLR_OUT[BULK_LIST_FILLED_BIT]
            ##1 $stable(BULK_CUR_PTR_OUT))
        else $error("bulk pointer changed with flag clear");

    // Read answer is the register as it stood at the strobe edge
    read_ctrl_a: assert property (
        REG_RD_IN && sel_ctrl_cur |=>
            REG_RDATA_OUT == $past(CTRL_CUR_PTR_OUT))
        else $error("control pointer read wrong");

    read_bulk_a: assert property (
        REG_RD_IN && sel_bulk_cur |=>
            REG_RDATA_OUT == $past(BULK_CUR_PTR_OUT))
        else $error("bulk pointer read wrong");

    read_idle_a: assert property (
        !REG_RD_IN |=> !REG_RDATA_VALID_OUT && $stable(REG_RDATA_OUT))
        else $error("read answer changed without a strobe");

endmodule

// File: verif/ocb_list_pointers_tb_top.sv
`timescale 1ns/100ps

`define CHK(NM, EXP, GOT) \
    begin \
        n_tests++; \
        if ((GOT) !== (EXP)) begin \
            err_total++; \
            $display("ERROR %s expected %h seen %h", NM, EXP, GOT); \
        end \
    end

module ocb_list_pointers_tb_top;
    import ocb_pkg::*;

    // ****************************************************************
    // Clock, stimulus and observed signals
    // ****************************************************************
    logic              core_clk   = 1'b0;
    logic              resetn     = 1'b0;
    logic [ADDR_W-1:0] reg_addr   = '0;
    logic              reg_wr     = 1'b0;
    logic              reg_rd     = 1'b0;
    logic [DATA_W-1:0] reg_wdata  = '0;
    logic [DATA_W-1:0] ctrl_reg   = '0;
    logic [DATA_W-1:0] cmd_status = '0;
    logic              init_load  = 1'b0;
    logic [DATA_W-1:0] hca_first  = '0;
    logic [DATA_W-1:0] ctrl_first = '0;
    logic [3:0]        ev         = '0;
    logic [DATA_W-1:0] ctrl_next  = '0;
    logic [DATA_W-1:0] bulk_next  = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic              rdata_valid;
    logic [DATA_W-1:0] clr;
    logic [DATA_W-1:0] ctrl_cur;
    logic [DATA_W-1:0] bulk_first;
    logic [DATA_W-1:0] bulk_cur;
    logic              ctrl_at_end;
    logic              bulk_at_end;
    int                err_total  = 0;
    int                n_tests    = 0;

    always #2.5 core_clk = ~core_clk;

    ocb_list_pointers i_ocb_list_pointers (
        .CORE_CLK_IN                  (core_clk),
        .RESETN_IN                    (resetn),
        .REG_ADDR_IN                  (reg_addr),
        .REG_WR_IN                    (reg_wr),
        .REG_RD_IN                    (reg_rd),
        .REG_WDATA_IN                 (reg_wdata),
        .REG_RDATA_OUT                (reg_rdata),
        .REG_RDATA_VALID_OUT          (rdata_valid),
        .CTRL_REG_IN                  (ctrl_reg),
        .CMD_STATUS_IN                (cmd_status),
        .CMD_STATUS_CLR_OUT           (clr),
        .INIT_LOAD_IN                 (init_load),
        .HOST_COMM_AREA_BULK_FIRST_IN (hca_first),
        .CTRL_FIRST_PTR_IN            (ctrl_first),
        .CTRL_ED_SERVED_IN            (ev[0]),
        .CTRL_NEXT_ED_IN              (ctrl_next),
        .CTRL_LIST_END_IN             (ev[1]),
        .BULK_ED_SERVED_IN            (ev[2]),
        .BULK_NEXT_ED_IN              (bulk_next),
        .BULK_LIST_END_IN             (ev[3]),
        .CTRL_CUR_PTR_OUT             (ctrl_cur),
        .BULK_FIRST_PTR_OUT           (bulk_first),
        .BULK_CUR_PTR_OUT             (bulk_cur),
        .CTRL_AT_END_OUT              (ctrl_at_end),
        .BULK_AT_END_OUT              (bulk_at_end)
    );

    // ****************************************************************
    // Bus and event tasks
    // ****************************************************************
    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge core_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge core_clk);
        reg_wr    = 1'b0;
    endtask

    task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge core_clk);
        reg_rd   = 1'b0;
        `CHK("read valid", 1'b1, rdata_valid)
        d = reg_rdata;
    endtask

    // Clear output is combinational, so it is sampled inside the pulse cycle
    task automatic fire(input logic [3:0] e, output logic [DATA_W-1:0] c);
        @(negedge core_clk);
        ev = e;
        #1 c = clr;
        @(negedge core_clk);
        ev = 4'h0;
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset_values();
        logic [DATA_W-1:0] d;
        reg_read(8'h24, d);
        `CHK("ctrl cur reset", 32'h0000_0000, d)
        reg_read(8'h28, d);
        `CHK("bulk first reset", 32'h0000_0000, d)
        reg_read(8'h2c, d);
        `CHK("bulk cur reset", 32'h0000_0000, d)
        `CHK("ctrl at end", 1'b1, ctrl_at_end)
        `CHK("bulk at end", 1'b1, bulk_at_end)
        $display("test reset_values done");
    endtask

    task automatic t_sw_access();
        logic [DATA_W-1:0] d;
        reg_write(8'h28, 32'h1234_5670);
        reg_read(8'h28, d);
        `CHK("bulk first rw", 32'h1234_5670, d)
        `CHK("bulk first out", 32'h1234_5670, bulk_first)
        reg_write(8'h2c, 32'ha5a5_a5a5);
        reg_read(8'h2c, d);
        `CHK("bulk cur rw", 32'ha5a5_a5a0, d)
        ctrl_reg = 32'h0000_0020;
        reg_write(8'h2c, 32'h0000_1110);
        reg_read(8'h2c, d);
        `CHK("bulk cur locked", 32'ha5a5_a5a0, d)
        ctrl_reg = 32'h0000_0000;
        reg_write(8'h24, 32'hffff_fff0);
        reg_read(8'h24, d);
        `CHK("ctrl cur ro", 32'h0000_0000, d)
        reg_write(8'h30, 32'hffff_ffff);
        reg_read(8'h30, d);
        `CHK("unmapped read", 32'h0000_0000, d)
        $display("test sw_access done");
    endtask

    task automatic t_ctrl_walk();
        logic [DATA_W-1:0] c;
        ctrl_first = 32'h0000_2008;
        ctrl_next  = 32'h0000_3345;
        fire(4'b0001, c);
        `CHK("ctrl advance", 32'h0000_3340, ctrl_cur)
        `CHK("ctrl not end", 1'b0, ctrl_at_end)
        fire(4'b0010, c);
        `CHK("end unfilled clr", 32'h0000_0000, c)
        `CHK("ctrl resumes", 32'h0000_3340, ctrl_cur)
        cmd_status = 32'h0000_0002;
        ctrl_next  = 32'h0000_4450;
        fire(4'b0011, c);
        `CHK("served beats end", 32'h0000_4450, ctrl_cur)
        `CHK("no clr on served", 32'h0000_0000, c)
        fire(4'b0010, c);
        `CHK("filled clr", 32'h0000_0002, c)
        `CHK("ctrl wrap", 32'h0000_2000, ctrl_cur)
        cmd_status = 32'h0000_0000;
        ctrl_next  = 32'h0000_0000;
        fire(4'b0001, c);
        `CHK("ctrl null end", 1'b1, ctrl_at_end)
        $display("test ctrl_walk done");
    endtask

    task automatic t_bulk_walk();
        logic [DATA_W-1:0] c;
        logic [DATA_W-1:0] d;
        hca_first = 32'h0000_888c;
        @(negedge core_clk);
        init_load = 1'b1;
        @(negedge core_clk);
        init_load = 1'b0;
        `CHK("init load", 32'h0000_8880, bulk_first)
        cmd_status = 32'h0000_0004;
        fire(4'b1000, c);
        `CHK("bulk clr", 32'h0000_0004, c)
        `CHK("bulk from head", 32'h0000_8880, bulk_cur)
        cmd_status = 32'h0000_0000;
        bulk_next  = 32'h0000_9991;
        fire(4'b0100, c);
        `CHK("bulk advance", 32'h0000_9990, bulk_cur)
        fire(4'b1000, c);
        reg_read(8'h2c, d);
        `CHK("bulk resumes", 32'h0000_9990, d)
        $display("test bulk_walk done");
    endtask

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (8) @(negedge core_clk);
        resetn = 1'b1;
        t_reset_values();
        t_sw_access();
        t_ctrl_walk();
        t_bulk_walk();
        end_sim();
    end

    // About 54 cycles expected; generous margin
    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        end_sim();
    end

endmodule
